// File: bitmap_mem.sv
// bitmap memory model holding orders, source and destination
`timescale 1ns/10ps
module bitmap_mem (
  // engine side
  input  wire        ref_clk,
  input  wire        mem_req,
  input  wire        mem_we,
  input  wire [31:0] mem_addr,
  input  wire [15:0] mem_wdata,
  output reg  [15:0] mem_rdata,
  output reg         mem_ack,
  // stall length
  input  wire [1:0]  lat
);
  reg [15:0] m [0:4095];
  reg [1:0]  wait_q = 2'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 16'h0000;
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    // idle data toggles so a stale word never passes for fresh
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack && wait_q < lat) begin
      wait_q <= wait_q + 2'h1;
    end else if (mem_req && !mem_ack) begin
      wait_q <= 2'h0;
      mem_ack <= 1'b1;
      if (mem_we) begin
        m[mem_addr[12:1]] <= mem_wdata;
      end else begin
        mem_rdata <= m[mem_addr[12:1]];
      end
    end
  end
endmodule // bitmap_mem

// File: blit_consts.vh
// constants of the expanded blit order engine
`ifndef BLIT_CONSTS_VH
`define BLIT_CONSTS_VH
// ==========================================================
// register byte offsets
`define OFF_CTRL     8'h00
`define OFF_ORDER    8'h04
`define OFF_BOOL     8'h08
`define OFF_LBASE    8'h0C
`define OFF_BEND     8'h10
`define OFF_DWARP    8'h14
`define OFF_STATUS   8'h18
// ==========================================================
// field positions
`define CTRL_START   0
`define CTRL_B2T     1
`define ST_BUSY      0
`define ST_DONE      1
`define ST_FAULT     2
`define ST_BADOP     3
// ==========================================================
// reset values
`define RST_BOOL     4'hC
`define RST_WORD     32'h00000000
// ==========================================================
// order layout, in 16-bit words from the order base
`define OPC_EXPANDED 8'h36
`define W_OPBAND     4'h0
`define W_DA_HI      4'h1
`define W_DA_LO      4'h2
`define W_FW         4'h3
`define W_FH         4'h4
`define W_SA_HI      4'h5
`define W_SA_LO      4'h6
`define W_SW         4'h7
`define W_SCALE      4'h8
`endif

// File: blit_props.sv
// assertions on the ports of the expanded blit engine
`timescale 1ns/10ps
`include "blit_consts.vh"
module blit_props (
  // clock and reset
  input wire        ref_clk,
  input wire        rst,
  // register bus
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // bitmap memory
  input wire        mem_req,
  input wire        mem_we,
  input wire [31:0] mem_addr,
  input wire [15:0] mem_wdata,
  input wire        mem_ack
);
  // ==========
  // order base and start tracking
  reg  [31:0] ord_q;
  reg         arm_q;
  wire        wr_ok = pready && pwrite;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ord_q <= 32'h0;
      arm_q <= 1'b0;
    end else begin
      if (wr_ok && paddr == `OFF_ORDER) begin
        ord_q <= {pwdata[31:1], 1'b0};
      end
      if (wr_ok && paddr == `OFF_CTRL && pwdata[`CTRL_START]) begin
        arm_q <= 1'b1;
      end else if (mem_req) begin
        arm_q <= 1'b0;
      end
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_apb_acc;
    psel && penable && !pready;
  endsequence
  sequence s_req_wait;
    mem_req && !mem_ack;
  endsequence
  property p_apb_wait;
    s_apb_acc |=> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_unmapped;
    pready && !pwrite && paddr > `OFF_STATUS |-> pslverr && prdata == 32'h0;
  endproperty
  property p_req_hold;
    s_req_wait |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
  endproperty
  property p_req_drop;
    mem_req && mem_ack |=> !mem_req;
  endproperty
  property p_even;
    mem_req |-> !mem_addr[0];
  endproperty
  property p_order_fetch;
    $rose(mem_req) && arm_q |-> !mem_we && mem_addr == ord_q;
  endproperty
  property p_opcode_kept;
    mem_req && mem_we && mem_addr == ord_q |-> mem_wdata[15:8] == `OPC_EXPANDED;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("register answer late");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  a_req_hold: assert property (p_req_hold)
    else $error("memory request changed while waiting");
  a_req_drop: assert property (p_req_drop)
    else $error("memory request held after ack");
  a_even: assert property (p_even)
    else $error("odd word address");
  a_order_fetch: assert property (p_order_fetch)
    else $error("first access is not the order base");
  a_opcode_kept: assert property (p_opcode_kept)
    else $error("rewritten order lost its opcode");
endmodule // blit_props
bind expanded_blit_to_banded_bitmap blit_props u_props (
  .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack
);

// File: expand_counter.v
// replication phase counter for one axis of the expansion
`timescale 1ns/10ps
module expand_counter #(
  parameter W = 4
) (
  // clock and control
  input  wire         ref_clk,
  input  wire         rst,
  input  wire         ce,
  // phase control
  input  wire         load,
  input  wire [W-1:0] load_val,
  input  wire         step,
  input  wire [W-1:0] limit,
  // state
  output wire [W-1:0] phase,
  output wire         wrap
);
  reg [W-1:0] phase_q;

  assign phase = phase_q;
  assign wrap  = step && (phase_q >= limit);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_q <= {W{1'b0}};
    end else if (ce) begin
      if (load) begin
        phase_q <= load_val;
      end else if (step) begin
        phase_q <= wrap ? {W{1'b0}} : phase_q + 1'b1;
      end
    end
  end
endmodule // expand_counter

// File: expanded_blit_to_banded_bitmap.v
// expanded source to banded bitmap blit order engine with APB registers
// Notes on behaviour
// - order is opcode 0x36, band, dest addr, width, height, source addr, warp, scales.
// - source is expanded then combined with destination by the boolean code.
// - physical destination address is logical address plus logical base offset.
// - smaller frame width or height applies only that part of the expansion.
// - each next source scanline starts source warp further on.
// - only the order's own source warp is used.
// - horizontal scale code is low nibble, factor code plus one.
// - unsupported horizontal codes give no horizontal scaling.
// - horizontal clip offset is high nibble, skips that many left expanded bits.
// - vertical scale code is low nibble, any value, factor code plus one.
// - vertical clip offset is high nibble, counted from the starting edge.
// - nonzero vertical offset skips that many expanded scanlines first.
// - band fault when the frame passes the band end address.
// - on fault the band number steps up, or down when bottom-to-top.
// - on fault addresses and vertical offset are rewritten for the next band.
// - on fault frame height is rewritten with the scanlines left.
`timescale 1ns/10ps
`include "blit_consts.vh"
module expanded_blit_to_banded_bitmap (
  // clock, reset, enable
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        ce,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // bitmap memory, 16-bit words at byte addresses
  output reg         mem_req,
  output reg         mem_we,
  output reg  [31:0] mem_addr,
  output reg  [15:0] mem_wdata,
  input  wire [15:0] mem_rdata,
  input  wire        mem_ack
);
  localparam S_IDLE  = 4'h0;
  localparam S_FETCH = 4'h1;
  localparam S_DEC   = 4'h2;
  localparam S_ROW   = 4'h3;
  localparam S_RDS   = 4'h4;
  localparam S_RDD   = 4'h5;
  localparam S_WRD   = 4'h6;
  localparam S_EROW  = 4'h7;
  localparam S_RW    = 4'h8;

  // ==========================================================
  // registers
  reg [3:0]  state_q;
  reg [31:0] order_q, lbase_q, bend_q, dwarp_q;
  reg [3:0]  bool_q;
  reg        b2t_q, busy_q, done_q, fault_q, badop_q;
  reg [3:0]  widx_q;
  reg [7:0]  band_q;
  reg [31:0] da_q, sa_q;
  reg [15:0] fw_q, fh_q, sw_q;
  reg [3:0]  horiz_clip_offset_q, horiz_scale_code_q, vert_clip_offset_q, vert_scale_code_q;
  reg [31:0] drow_q, srow_q, dcol_q, scol_q;
  reg [15:0] cols_q, rows_q;
  reg        sbit_q;

  wire apb_acc = psel && penable && pready;
  wire apb_wr  = apb_acc && pwrite;
  wire mapped  = (paddr == `OFF_CTRL) || (paddr == `OFF_ORDER) || (paddr == `OFF_BOOL) ||
                 (paddr == `OFF_LBASE) || (paddr == `OFF_BEND) || (paddr == `OFF_DWARP) ||
                 (paddr == `OFF_STATUS);
  wire start   = apb_wr && (paddr == `OFF_CTRL) && pwdata[`CTRL_START] && !busy_q;
  wire st_clr  = apb_wr && (paddr == `OFF_STATUS);

  // ==========================================================
  // expansion control
  reg hx_ok;
  always @* begin
    case (horiz_scale_code_q)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'hB, 4'hF: hx_ok = 1'b1;
      default: hx_ok = 1'b0;
    endcase
  end
  wire [3:0] hlim  = hx_ok ? horiz_scale_code_q : 4'h0;
  wire [3:0] hoff  = hx_ok ? horiz_clip_offset_q : 4'h0;
  // fault when the next row would start beyond the band end in travel direction
  wire band_fault = b2t_q ? (drow_q < bend_q) : (drow_q >= bend_q);

  wire       mem_done = mem_req && mem_ack;
  wire       row_go = (state_q == S_ROW) && (rows_q != 16'h0000) && !band_fault;
  wire       pix_done = (state_q == S_WRD) && mem_done;
  wire       row_done = (state_q == S_EROW);
  wire       h_wrap, v_wrap;
  wire [3:0] v_phase;

  expand_counter #(.W(4)) u_hcnt (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .load     (row_go),
    .load_val (hoff),
    .step     (pix_done),
    .limit    (hlim),
    .phase    (),
    .wrap     (h_wrap)
  );

  expand_counter #(.W(4)) u_vcnt (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .load     (state_q == S_DEC),
    .load_val (vert_clip_offset_q),
    .step     (row_done),
    .limit    (vert_scale_code_q),
    .phase    (v_phase),
    .wrap     (v_wrap)
  );

  wire [31:0] dword_addr = {3'h0, dcol_q[31:4], 1'b0};
  wire [31:0] sword_addr = {3'h0, scol_q[31:4], 1'b0};
  wire [31:0] ord_word   = order_q + {27'h0, widx_q, 1'b0};
  wire        dbit       = mem_rdata[~dcol_q[3:0]];
  wire        res_bit    = bool_q[{sbit_q, dbit}];
  wire [31:0] da_log     = drow_q - lbase_q;
  wire [7:0]  band_nx    = b2t_q ? band_q - 8'h01 : band_q + 8'h01;

  reg [15:0] rw_data;
  always @* begin
    case (widx_q)
      `W_OPBAND: rw_data = {`OPC_EXPANDED, band_nx};
      `W_DA_HI:  rw_data = da_log[31:16];
      `W_DA_LO:  rw_data = da_log[15:0];
      `W_FH:     rw_data = rows_q;
      `W_SA_HI:  rw_data = srow_q[31:16];
      `W_SA_LO:  rw_data = srow_q[15:0];
      `W_SCALE:  rw_data = {horiz_clip_offset_q, horiz_scale_code_q, v_phase, vert_scale_code_q};
      default:   rw_data = mem_rdata;
    endcase
  end

  // ==========================================================
  // apb slave, one wait state per transfer
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RST_WORD;
      order_q <= `RST_WORD;
      lbase_q <= `RST_WORD;
      bend_q  <= `RST_WORD;
      dwarp_q <= `RST_WORD;
      bool_q  <= `RST_BOOL;
      b2t_q   <= 1'b0;
    end else if (ce) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready) begin
        case (paddr)
          `OFF_CTRL:   prdata <= {30'h0, b2t_q, 1'b0};
          `OFF_ORDER:  prdata <= order_q;
          `OFF_BOOL:   prdata <= {28'h0, bool_q};
          `OFF_LBASE:  prdata <= lbase_q;
          `OFF_BEND:   prdata <= bend_q;
          `OFF_DWARP:  prdata <= dwarp_q;
          `OFF_STATUS: prdata <= {28'h0, badop_q, fault_q, done_q, busy_q};
          default:     prdata <= `RST_WORD;
        endcase
      end
      // geometry is frozen while an order runs
      if (apb_wr && !busy_q) begin
        case (paddr)
          `OFF_CTRL:  b2t_q   <= pwdata[`CTRL_B2T];
          `OFF_ORDER: order_q <= {pwdata[31:1], 1'b0};
          `OFF_BOOL:  bool_q  <= pwdata[3:0];
          `OFF_LBASE: lbase_q <= pwdata;
          `OFF_BEND:  bend_q  <= pwdata;
          `OFF_DWARP: dwarp_q <= pwdata;
          default:    order_q <= order_q;
        endcase
      end
    end
  end

  // ==========================================================
  // order engine
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q   <= S_IDLE;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      fault_q   <= 1'b0;
      badop_q   <= 1'b0;
      widx_q    <= 4'h0;
      band_q    <= 8'h00;
      da_q      <= `RST_WORD;
      sa_q      <= `RST_WORD;
      fw_q      <= 16'h0000;
      fh_q      <= 16'h0000;
      sw_q      <= 16'h0000;
      horiz_clip_offset_q    <= 4'h0;
      horiz_scale_code_q    <= 4'h0;
      vert_clip_offset_q    <= 4'h0;
      vert_scale_code_q    <= 4'h0;
      drow_q    <= `RST_WORD;
      srow_q    <= `RST_WORD;
      dcol_q    <= `RST_WORD;
      scol_q    <= `RST_WORD;
      cols_q    <= 16'h0000;
      rows_q    <= 16'h0000;
      sbit_q    <= 1'b0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= `RST_WORD;
      mem_wdata <= 16'h0000;
    end else if (ce) begin
      // write one to clear; a completion in the same cycle wins
      if (st_clr) begin
        if (pwdata[`ST_DONE])  done_q  <= 1'b0;
        if (pwdata[`ST_FAULT]) fault_q <= 1'b0;
        if (pwdata[`ST_BADOP]) badop_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          if (start) begin
            busy_q  <= 1'b1;
            widx_q  <= `W_OPBAND;
            state_q <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= ord_word;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            widx_q  <= widx_q + 4'h1;
            case (widx_q)
              `W_OPBAND: begin
                band_q <= mem_rdata[7:0];
                if (mem_rdata[15:8] != `OPC_EXPANDED) begin
                  badop_q <= 1'b1;
                  busy_q  <= 1'b0;
                  state_q <= S_IDLE;
                end
              end
              `W_DA_HI: da_q[31:16] <= mem_rdata;
              `W_DA_LO: da_q[15:0]  <= mem_rdata;
              `W_FW:    fw_q        <= mem_rdata;
              `W_FH:    fh_q        <= mem_rdata;
              `W_SA_HI: sa_q[31:16] <= mem_rdata;
              `W_SA_LO: sa_q[15:0]  <= mem_rdata;
              `W_SW:    sw_q        <= mem_rdata;
              default: begin
                horiz_clip_offset_q  <= mem_rdata[15:12];
                horiz_scale_code_q  <= mem_rdata[11:8];
                vert_clip_offset_q  <= mem_rdata[7:4];
                vert_scale_code_q  <= mem_rdata[3:0];
                state_q <= S_DEC;
              end
            endcase
          end
        end
        S_DEC: begin
          drow_q  <= da_q + lbase_q;
          srow_q  <= sa_q;
          rows_q  <= fh_q;
          state_q <= S_ROW;
        end
        S_ROW: begin
          if (rows_q == 16'h0000) begin
            done_q  <= 1'b1;
            busy_q  <= 1'b0;
            state_q <= S_IDLE;
          end else if (band_fault) begin
            widx_q  <= `W_OPBAND;
            state_q <= S_RW;
          end else begin
            dcol_q  <= drow_q;
            scol_q  <= srow_q;
            cols_q  <= fw_q;
            state_q <= (fw_q == 16'h0000) ? S_EROW : S_RDS;
          end
        end
        S_RDS: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= sword_addr;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            sbit_q  <= mem_rdata[~scol_q[3:0]];
            state_q <= S_RDD;
          end
        end
        S_RDD: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= dword_addr;
          end else if (mem_ack) begin
            mem_req   <= 1'b0;
            mem_wdata <= mem_rdata;
            mem_wdata[~dcol_q[3:0]] <= res_bit;
            state_q   <= S_WRD;
          end
        end
        S_WRD: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we  <= 1'b1;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            dcol_q  <= dcol_q + 32'h1;
            cols_q  <= cols_q - 16'h1;
            if (h_wrap) scol_q <= scol_q + 32'h1;
            state_q <= (cols_q == 16'h0001) ? S_EROW : S_RDS;
          end
        end
        S_EROW: begin
          drow_q <= b2t_q ? drow_q - dwarp_q : drow_q + dwarp_q;
          rows_q <= rows_q - 16'h1;
          if (v_wrap) begin
            srow_q <= b2t_q ? srow_q - {16'h0, sw_q} : srow_q + {16'h0, sw_q};
          end
          state_q <= S_ROW;
        end
        S_RW: begin
          if (!mem_req) begin
            if (widx_q == `W_FW || widx_q == `W_SW) begin
              widx_q <= widx_q + 4'h1;
            end else begin
              mem_req   <= 1'b1;
              mem_we    <= 1'b1;
              mem_addr  <= ord_word;
              mem_wdata <= rw_data;
            end
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            widx_q  <= widx_q + 4'h1;
            if (widx_q == `W_SCALE) begin
              fault_q <= 1'b1;
              busy_q  <= 1'b0;
              state_q <= S_IDLE;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // expanded_blit_to_banded_bitmap

// File: expanded_blit_to_banded_bitmap_tb_top.sv
// self-checking bench for the expanded blit engine
`timescale 1ns/10ps
`include "blit_consts.vh"
`define CHK(n, e, a) begin \
  num_checks = num_checks + 1; \
  if ((a) !== (e)) begin \
    err_total = err_total + 1; \
    $display("BAD %0s exp %h got %h", n, e, a); \
  end \
end
module expanded_blit_to_banded_bitmap_tb_top;
  // ==========
  // signals
  reg         ref_clk, rst, ce, psel, penable, pwrite, er_q;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd_q;
  wire [31:0] prdata, mem_addr;
  wire        pready, pslverr, mem_req, mem_we, mem_ack;
  wire [15:0] mem_wdata, mem_rdata;
  reg  [1:0]  lat;
  reg  [15:0] ex [0:4095];
  integer     seed, err_total, num_checks, cyc, i, k, xm, xo, ym, yo, b, w, h;
  // horizontal codes to walk: all supported ones, then two unsupported ones
  localparam [39:0] XM_SET = 40'h94FB753210;
  expanded_blit_to_banded_bitmap u_dut (
    .ref_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack
  );
  bitmap_mem u_mem (
    .ref_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .lat
  );
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      err_total = err_total + 1;
      stop_test;
    end
  end
  // ==========
  // helpers
  function automatic integer rnd(input integer n);
    rnd = $unsigned($random(seed)) % n;
  endfunction
  function automatic integer fac(input integer x);
    fac = (x inside {0, 1, 2, 3, 5, 7, 11, 15}) ? x + 1 : 1;
  endfunction
  function automatic bit_of(input integer a);
    bit_of = ex[a / 16][15 - a % 16];
  endfunction
  task apb(input reg wr, input reg [7:0] a, input reg [31:0] d);
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd_q = prdata;
      er_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // runs one order; the model applies rows 0..nr-1 to the expected image
  task blit(input reg [7:0] opc, input reg b2t, input reg [31:0] bend, input reg [3:0] x,
            input reg [3:0] xf, input reg [3:0] y, input reg [3:0] yf, input integer fw,
            input integer fh, input integer nr, input reg [1:0] st);
    integer r, c, f, sg, sb, db, n;
    reg [3:0] bc;
    begin
      bc = rnd(16);
      lat <= rnd(4);
      f = fac(x);
      sg = b2t ? -1 : 1;
      for (i = 0; i < 4096; i = i + 1) ex[i] = $random(seed);
      ex[0] = {opc, 8'h05};
      ex[1] = 16'h0000;
      ex[2] = 16'h3000;
      ex[3] = fw[15:0];
      ex[4] = fh[15:0];
      ex[5] = 16'h0000;
      ex[6] = 16'h1000;
      ex[7] = 16'h0018;
      ex[8] = {xf, x, yf, y};
      for (i = 0; i < 4096; i = i + 1) u_mem.m[i] = ex[i];
      for (r = 0; r < nr; r = r + 1) begin
        for (c = 0; c < fw; c = c + 1) begin
          sb = 'h1000 + sg * ((yf + r) / (y + 1)) * 24 + ((f == 1) ? c : (xf + c) / f);
          db = 'h8000 + sg * r * 128 + c;
          ex[db / 16][15 - db % 16] = bc[{bit_of(sb), bit_of(db)}];
        end
      end
      apb(1'b1, `OFF_BOOL, {28'h0, bc});
      apb(1'b1, `OFF_LBASE, 32'h5000);
      apb(1'b1, `OFF_BEND, bend);
      apb(1'b1, `OFF_DWARP, 32'h80);
      apb(1'b1, `OFF_CTRL, {30'h0, b2t, 1'b0});
      apb(1'b1, `OFF_CTRL, {30'h0, b2t, 1'b1});
      rd_q = 32'h1;
      for (n = 0; n < 5000 && rd_q[`ST_BUSY] !== 1'b0; n = n + 1) apb(1'b0, `OFF_STATUS, 0);
      `CHK("status", {st, st == 2'b00, 1'b0}, rd_q[3:0])
      apb(1'b1, `OFF_STATUS, 32'hE);
    end
  endtask
  task check_mem(input string nm);
    begin
      for (i = 0; i < 4096; i = i + 1) `CHK("word", ex[i], u_mem.m[i])
      $display("test %0s done", nm);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  // ==========
  // main sequence
  initial begin
    {ref_clk, psel, penable, pwrite, paddr, pwdata, lat} = 46'h0;
    ce = 1'b1;
    rst = 1'b1;
    seed = 32'hFCB05BBF;
    {err_total, num_checks, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (k = 0; k < 8; k = k + 1) begin
      apb(1'b0, {k[5:0], 2'b00}, 0);
      `CHK("reset value", (k == 2) ? {28'h0, `RST_BOOL} : 32'h0, rd_q)
      `CHK("slave error", k == 7, er_q)
    end
    $display("test registers done");
    apb(1'b1, `OFF_ORDER, 32'h0);
    for (k = 0; k < 10; k = k + 1) begin
      xm = XM_SET[k * 4 +: 4];
      ym = rnd(16);
      yo = rnd(ym + 1);
      xo = rnd(xm + 1);
      b = rnd(2);
      w = 4 * fac(xm) - ((fac(xm) > 1) ? xo : 0);
      w = 1 + rnd((w < 20) ? w : 20);
      h = 3 * (ym + 1) - yo;
      h = 1 + rnd((h < 6) ? h : 6);
      blit(`OPC_EXPANDED, b, b ? 0 : 32'hFFFFFFFF, xm, xo, ym, yo, w, h, h, 2'b00);
      check_mem("expand");
    end
    blit(`OPC_EXPANDED, 1'b0, 32'h8100, 1, 1, 3, 3, 4, 5, 2, 2'b01);
    ex[0] = 16'h3606;
    ex[2] = 16'h3100;
    ex[4] = 16'h0003;
    ex[6] = 16'h1018;
    ex[8] = 16'h1113;
    check_mem("band fault down");
    blit(`OPC_EXPANDED, 1'b1, 32'h7F80, 1, 1, 3, 3, 4, 5, 2, 2'b01);
    ex[0] = 16'h3604;
    ex[2] = 16'h2F00;
    ex[4] = 16'h0003;
    ex[6] = 16'h0FE8;
    ex[8] = 16'h1113;
    check_mem("band fault up");
    blit(8'h35, 1'b0, 32'hFFFFFFFF, 0, 0, 0, 0, 4, 1, 0, 2'b10);
    check_mem("bad opcode");
    stop_test;
  end
endmodule // expanded_blit_to_banded_bitmap_tb_top
